// ===== common/pbc_pkg.sv
// package: constants, types and decode functions of the bus pin controller
package pbc_pkg;
  localparam int ADDR_W = 20;
  localparam int IO_ADDR_W = 16;
  localparam int REFRESH_CYCLE_N_W = 8;
  localparam int DATA_W = 8;
  localparam int XREQ_N = 2;
  localparam int SYNC_W = 8;
  localparam int SY_WAIT = 0;
  localparam int SY_HOLD = 1;
  localparam int SY_NMI = 2;
  localparam int SY_IRQ = 3;
  localparam int SY_XREQ = 6;
  localparam int TIMER_PULSE_OUT_BIT = 18;
  localparam logic [ADDR_W-1:0] NMI_VECTOR = 20'h00066;
  localparam logic [ADDR_W-1:0] ADDR_RST = 20'h00000;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0, S_T1 = 3'h1, S_T2 = 3'h3, S_T3 = 3'h2,
    S_TW = 3'h7, S_GRANT = 3'h4, S_STOP = 3'h6
  } pbc_state_type;

  typedef enum logic [3:0] {
    CYC_FETCH1 = 4'h0, CYC_FETCHN = 4'h1, CYC_MEM_RD = 4'h2, CYC_MEM_WR = 4'h3,
    CYC_IO_RD = 4'h4, CYC_IO_WR = 4'h5, CYC_REFRESH = 4'h6, CYC_ACK0 = 4'h7,
    CYC_ACK12 = 4'h8
  } pbc_cyc_type;

  typedef enum logic [1:0] {
    TAKE_NONE = 2'h0, TAKE_NMI = 2'h1, TAKE_IRQ0 = 2'h2, TAKE_IRQ12 = 2'h3
  } pbc_take_type;

  function automatic logic pbc_is_mem(pbc_cyc_type k);
    return k inside {CYC_FETCH1, CYC_FETCHN, CYC_MEM_RD, CYC_MEM_WR, CYC_REFRESH};
  endfunction : pbc_is_mem

  function automatic logic pbc_is_io(pbc_cyc_type k);
    return k inside {CYC_IO_RD, CYC_IO_WR, CYC_ACK0};
  endfunction : pbc_is_io

  function automatic logic pbc_is_read(pbc_cyc_type k);
    return k inside {CYC_FETCH1, CYC_FETCHN, CYC_MEM_RD, CYC_IO_RD};
  endfunction : pbc_is_read

  function automatic logic pbc_is_write(pbc_cyc_type k);
    return k inside {CYC_MEM_WR, CYC_IO_WR};
  endfunction : pbc_is_write

  function automatic logic pbc_is_first(pbc_cyc_type k);
    return k inside {CYC_FETCH1, CYC_FETCHN, CYC_ACK0};
  endfunction : pbc_is_first

  function automatic logic [ADDR_W-1:0] pbc_addr_out(pbc_cyc_type k, logic [ADDR_W-1:0] a);
    if (pbc_is_io(k)) begin
      return {{(ADDR_W-IO_ADDR_W){1'b0}}, a[IO_ADDR_W-1:0]};
    end
    if (k == CYC_REFRESH) begin
      return {{(ADDR_W-REFRESH_CYCLE_N_W){1'b0}}, a[REFRESH_CYCLE_N_W-1:0]};
    end
    return a;
  endfunction : pbc_addr_out
endpackage : pbc_pkg

// ===== common/pbc_sync_if.sv
// interface: synchronised pin levels and the NMI edge
`timescale 1ns/1ps
interface pbc_sync_if;
  import pbc_pkg::*;
  logic [SYNC_W-1:0] lvl_n;
  logic nmi_fall;
  modport src(output lvl_n, output nmi_fall);
  modport dst(input lvl_n, input nmi_fall);
endinterface : pbc_sync_if

// ===== rtl/pbc_pin_sync.sv
// module: two-stage synchronisers for the input pins and NMI edge detect
`timescale 1ns/1ps
module pbc_pin_sync import pbc_pkg::*; (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_clk_en,
  input wire logic [SYNC_W-1:0] i_pins_n,
  pbc_sync_if.src o_sync
);
  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic nmi_old;
    logic nmi_fall;
  } pbc_sync_st_type;

  localparam pbc_sync_st_type SYNC_RST = '{s1: '1, s2: '1, nmi_old: 1'b1, nmi_fall: 1'b0};

  pbc_sync_st_type st_reg;
  pbc_sync_st_type st_next;

  always_comb begin
    st_next = st_reg;
    st_next.s1 = i_pins_n;
    st_next.s2 = st_reg.s1;
    st_next.nmi_old = st_reg.s2[SY_NMI];
    st_next.nmi_fall = st_reg.nmi_old & ~st_reg.s2[SY_NMI];
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      st_reg <= SYNC_RST;
    end else if (i_clk_en) begin
      st_reg <= st_next;
    end
  end

  assign o_sync.lvl_n = st_reg.s2;
  assign o_sync.nmi_fall = st_reg.nmi_fall;
endmodule : pbc_pin_sync

// ===== rtl/pbc_xfer_sense.sv
// module: level or edge sensing of the transfer request inputs
`timescale 1ns/1ps
module pbc_xfer_sense import pbc_pkg::*; (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_clk_en,
  pbc_sync_if.dst i_sync,
  input wire logic [XREQ_N-1:0] i_edge_mode,
  input wire logic [XREQ_N-1:0] i_xfer_ack,
  output logic [XREQ_N-1:0] o_xfer_ready
);
  typedef struct packed {
    logic [XREQ_N-1:0] old_n;
    logic [XREQ_N-1:0] pend;
  } pbc_xfer_st_type;

  localparam pbc_xfer_st_type XFER_RST = '{old_n: '1, pend: '0};

  pbc_xfer_st_type st_reg;
  pbc_xfer_st_type st_next;
  logic [XREQ_N-1:0] req_n;

  assign req_n = i_sync.lvl_n[SY_XREQ +: XREQ_N];

  always_comb begin
    st_next = st_reg;
    st_next.old_n = req_n;
    // a new falling edge beats an acknowledge in the same cycle
    st_next.pend = (st_reg.old_n & ~req_n) | (st_reg.pend & ~i_xfer_ack);
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      st_reg <= XFER_RST;
    end else if (i_clk_en) begin
      st_reg <= st_next;
    end
  end

  assign o_xfer_ready = (i_edge_mode & st_reg.pend) | (~i_edge_mode & ~req_n);
endmodule : pbc_xfer_sense

// ===== rtl/pbc_bus_ctrl.sv
// module: external bus state machine, strobes, status pins and interrupt arbitration
`timescale 1ns/1ps
module pbc_bus_ctrl import pbc_pkg::*; (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_clk_en,
  input wire logic i_cyc_req,
  input wire pbc_cyc_type i_cyc_kind,
  input wire logic i_cyc_dma,
  input wire logic [ADDR_W-1:0] i_cyc_addr,
  input wire logic [DATA_W-1:0] i_cyc_wdata,
  output logic o_cyc_ready,
  output logic o_cyc_done,
  output logic [DATA_W-1:0] o_cyc_rdata,
  input wire logic i_instr_end,
  input wire logic i_int_en,
  input wire logic i_halt_req,
  input wire logic i_sleep_req,
  output pbc_take_type o_take,
  output logic [ADDR_W-1:0] o_take_vec,
  input wire logic [XREQ_N-1:0] i_xfer_edge_mode,
  input wire logic [XREQ_N-1:0] i_xfer_ack,
  output logic [XREQ_N-1:0] o_xfer_ready,
  input wire logic i_timer_pulse_out_sel,
  input wire logic i_timer_pulse,
  input wire logic i_wait_n,
  input wire logic i_bus_hold_request_n,
  input wire logic i_nmi_n,
  input wire logic i_irq0_n,
  input wire logic i_irq1_n,
  input wire logic i_irq2_n,
  input wire logic i_xfer_request0_n,
  input wire logic i_xfer_request1_n,
  input wire logic [DATA_W-1:0] i_data,
  output logic [DATA_W-1:0] o_data,
  output logic o_data_oe,
  output logic [ADDR_W-1:0] o_addr,
  output logic [ADDR_W-1:0] o_addr_oe,
  output logic o_mem_cycle_n,
  output logic o_io_cycle_n,
  output logic o_rd_n,
  output logic o_wr_n,
  output logic o_strobe_oe,
  output logic o_refresh_cycle_n,
  output logic o_first_fetch_n,
  output logic o_cpu_phase_flag,
  output logic o_stop_n,
  output logic o_bus_grant_n,
  output logic o_sys_clk_out,
  output logic o_cycle_clk
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    pbc_state_type state;
    pbc_cyc_type kind;
    logic dma;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] din1;
    logic [DATA_W-1:0] din2;
    logic [DATA_W-1:0] rdata;
    logic done;
    pbc_take_type take;
    logic [ADDR_W-1:0] vec;
    logic nmi_pend;
    logic sleep;
    logic timer_pulse_out_role;
    logic sys_clk;
    logic cyc_clk;
    logic [ADDR_W-1:0] pin_addr;
    logic addr_oe;
    logic data_oe;
    logic strobe_oe;
    logic mem_n;
    logic io_n;
    logic rd_n;
    logic wr_n;
    logic refresh_cycle_n_n;
    logic ff_n;
    logic phase;
    logic stop_n;
    logic grant_n;
  } pbc_bus_st_type;

  // strobes driven high, buses floating, timer role off
  localparam pbc_bus_st_type BUS_RST = '{
    state: S_IDLE,
    kind: CYC_MEM_RD,
    dma: 1'b0,
    addr: ADDR_RST,
    wdata: DATA_RST,
    din1: DATA_RST,
    din2: DATA_RST,
    rdata: DATA_RST,
    done: 1'b0,
    take: TAKE_NONE,
    vec: ADDR_RST,
    nmi_pend: 1'b0,
    sleep: 1'b0,
    timer_pulse_out_role: 1'b0,
    sys_clk: 1'b0,
    cyc_clk: 1'b0,
    pin_addr: ADDR_RST,
    addr_oe: 1'b0,
    data_oe: 1'b0,
    strobe_oe: 1'b1,
    mem_n: 1'b1,
    io_n: 1'b1,
    rd_n: 1'b1,
    wr_n: 1'b1,
    refresh_cycle_n_n: 1'b1,
    ff_n: 1'b1,
    phase: 1'b1,
    stop_n: 1'b1,
    grant_n: 1'b1
  };

  pbc_bus_st_type st_reg;
  pbc_bus_st_type st_next;

  // ****************************************
  // input pins
  // ****************************************
  pbc_sync_if sy();

  logic hold_req;
  logic wait_req;
  logic [2:0] irq_req;
  logic wake;
  logic act;
  logic late;
  logic stop;

  pbc_pin_sync u_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_clk_en(i_clk_en),
    .i_pins_n({i_xfer_request1_n, i_xfer_request0_n, i_irq2_n, i_irq1_n, i_irq0_n,
               i_nmi_n, i_bus_hold_request_n, i_wait_n}),
    .o_sync(sy)
  );

  pbc_xfer_sense u_xfer (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_clk_en(i_clk_en),
    .i_sync(sy),
    .i_edge_mode(i_xfer_edge_mode),
    .i_xfer_ack(i_xfer_ack),
    .o_xfer_ready(o_xfer_ready)
  );

  assign hold_req = ~sy.lvl_n[SY_HOLD];
  assign wait_req = ~sy.lvl_n[SY_WAIT];
  assign irq_req = ~sy.lvl_n[SY_IRQ +: 3];
  assign wake = st_reg.nmi_pend | sy.nmi_fall | (|irq_req);

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_next = st_reg;
    st_next.din1 = i_data;
    st_next.din2 = st_reg.din1;
    st_next.done = 1'b0;
    st_next.take = TAKE_NONE;
    st_next.sys_clk = ~st_reg.sys_clk;
    st_next.timer_pulse_out_role = i_timer_pulse_out_sel;
    st_next.nmi_pend = sy.nmi_fall | st_reg.nmi_pend;

    // instruction boundary: hold, then NMI, then irq0, then irq1/irq2
    if (i_instr_end && !hold_req && st_reg.state != S_GRANT) begin
      if (st_reg.nmi_pend) begin
        st_next.take = TAKE_NMI;
        st_next.vec = NMI_VECTOR;
        st_next.nmi_pend = sy.nmi_fall;
      end else if (i_int_en && irq_req[0]) begin
        st_next.take = TAKE_IRQ0;
        st_next.vec = ADDR_RST;
      end else if (i_int_en && (|irq_req[2:1])) begin
        st_next.take = TAKE_IRQ12;
        st_next.vec = ADDR_RST;
      end
    end

    unique case (st_reg.state)
      S_IDLE: begin
        if (hold_req) begin
          st_next.state = S_GRANT;
        end else if (i_halt_req || i_sleep_req) begin
          st_next.state = S_STOP;
          st_next.sleep = i_sleep_req;
        end else if (i_cyc_req) begin
          st_next.state = S_T1;
          st_next.kind = i_cyc_kind;
          st_next.dma = i_cyc_dma;
          st_next.addr = i_cyc_addr;
          st_next.wdata = i_cyc_wdata;
        end
      end
      S_T1: begin
        st_next.state = S_T2;
      end
      S_T2, S_TW: begin
        st_next.state = wait_req ? S_TW : S_T3;
      end
      S_T3: begin
        st_next.state = S_IDLE;
        st_next.done = 1'b1;
        if (pbc_is_read(st_reg.kind)) begin
          st_next.rdata = st_reg.din2;
        end
      end
      S_GRANT: begin
        if (!hold_req) begin
          st_next.state = S_IDLE;
        end
      end
      S_STOP: begin
        if (hold_req) begin
          st_next.state = S_GRANT;
        end else if (wake) begin
          st_next.state = S_IDLE;
        end
      end
      default: begin
        st_next.state = S_IDLE;
      end
    endcase

    // pin levels follow the state being entered
    act = st_next.state inside {S_T1, S_T2, S_TW, S_T3};
    late = st_next.state inside {S_T2, S_TW, S_T3};
    stop = st_next.state == S_STOP;
    st_next.grant_n = st_next.state != S_GRANT;
    st_next.addr_oe = st_next.grant_n;
    st_next.strobe_oe = st_next.grant_n;
    st_next.pin_addr = pbc_addr_out(st_next.kind, st_next.addr);
    st_next.mem_n = ~(act & pbc_is_mem(st_next.kind));
    st_next.io_n = ~(act & pbc_is_io(st_next.kind));
    st_next.rd_n = ~(act & pbc_is_read(st_next.kind));
    st_next.wr_n = ~(late & pbc_is_write(st_next.kind));
    st_next.data_oe = act & pbc_is_write(st_next.kind);
    st_next.refresh_cycle_n_n = ~(act & (st_next.kind == CYC_REFRESH));
    st_next.ff_n = ~((act & pbc_is_first(st_next.kind)) | (stop & ~st_next.sleep));
    st_next.phase = ~((act & ((st_next.kind == CYC_FETCH1) | st_next.dma)) | stop);
    st_next.stop_n = ~stop;
    st_next.cyc_clk = late;
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      st_reg <= BUS_RST;
    end else if (i_clk_en) begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  always_comb begin
    o_addr = st_reg.pin_addr;
    o_addr_oe = {ADDR_W{st_reg.addr_oe}};
    if (st_reg.timer_pulse_out_role) begin
      o_addr[TIMER_PULSE_OUT_BIT] = i_timer_pulse;
      o_addr_oe[TIMER_PULSE_OUT_BIT] = 1'b1;
    end
  end

  assign o_cyc_ready = (st_reg.state == S_IDLE) & ~hold_req & ~i_halt_req & ~i_sleep_req;
  assign o_cyc_done = st_reg.done;
  assign o_cyc_rdata = st_reg.rdata;
  assign o_take = st_reg.take;
  assign o_take_vec = st_reg.vec;
  assign o_data = st_reg.wdata;
  assign o_data_oe = st_reg.data_oe;
  assign o_mem_cycle_n = st_reg.mem_n;
  assign o_io_cycle_n = st_reg.io_n;
  assign o_rd_n = st_reg.rd_n;
  assign o_wr_n = st_reg.wr_n;
  assign o_strobe_oe = st_reg.strobe_oe;
  assign o_refresh_cycle_n = st_reg.refresh_cycle_n_n;
  assign o_first_fetch_n = st_reg.ff_n;
  assign o_cpu_phase_flag = st_reg.phase;
  assign o_stop_n = st_reg.stop_n;
  assign o_bus_grant_n = st_reg.grant_n;
  assign o_sys_clk_out = st_reg.sys_clk;
  assign o_cycle_clk = st_reg.cyc_clk;

  // ****************************************
  // checks
  // ****************************************
  sequence s_hold_taken;
    st_reg.state == S_IDLE && hold_req && i_clk_en;
  endsequence

  sequence s_all_float;
    !o_bus_grant_n && !o_addr_oe[0] && !o_data_oe && !o_strobe_oe;
  endsequence

  sequence s_halt_taken;
    st_reg.state == S_IDLE && !hold_req && i_halt_req && i_clk_en;
  endsequence

  sequence s_read_end;
    st_reg.state == S_T3 && pbc_is_read(st_reg.kind) && i_clk_en;
  endsequence

  chk_hold_grant: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // hold floats bus
    s_hold_taken |=> s_all_float) else $error("bus hold not granted with floating bus");

  chk_grant_stays: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // grant held
    !o_bus_grant_n && hold_req && i_clk_en |=> !o_bus_grant_n) else $error("grant dropped during hold");

  chk_reset_pins: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // reset levels
    $rose(i_rst_b) |-> o_mem_cycle_n && o_io_cycle_n && o_rd_n && o_wr_n && o_refresh_cycle_n
      && o_strobe_oe && !o_cycle_clk && o_addr_oe == '0 && !o_data_oe) else $error("bad pins after reset");

  chk_ack0_pair: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // irq0 ack strobes
    st_reg.state == S_T2 && st_reg.kind == CYC_ACK0 |-> !o_io_cycle_n && !o_first_fetch_n && o_mem_cycle_n)
    else $error("irq0 acknowledge strobes wrong");

  chk_ack12_quiet: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // quiet ack
    st_reg.state == S_T2 && st_reg.kind == CYC_ACK12 |-> o_io_cycle_n && o_first_fetch_n)
    else $error("irq1/irq2 acknowledge drove fetch or io strobe");

  chk_refresh_addr: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // refresh cycle
    !o_refresh_cycle_n && !st_reg.timer_pulse_out_role |-> !o_mem_cycle_n && o_addr[ADDR_W-1:REFRESH_CYCLE_N_W] == '0)
    else $error("refresh cycle without memory strobe or with high address bits");

  chk_io_range: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // io address
    !o_io_cycle_n && !st_reg.timer_pulse_out_role |-> o_addr[ADDR_W-1:IO_ADDR_W] == '0 && o_mem_cycle_n)
    else $error("io cycle address above 64 KB");

  chk_nmi_first: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // nmi wins
    st_reg.nmi_pend && i_instr_end && !hold_req && i_clk_en && st_reg.state != S_GRANT
      |=> o_take == TAKE_NMI && o_take_vec == NMI_VECTOR) else $error("nmi not taken with its vector");

  chk_irq0_rank: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // irq0 order
    !st_reg.nmi_pend && irq_req[0] && i_int_en && i_instr_end && !hold_req && i_clk_en
      && st_reg.state != S_GRANT |=> o_take == TAKE_IRQ0) else $error("irq0 not taken in priority");

  chk_halt_status: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // halt status
    s_halt_taken |=> !o_stop_n && !o_first_fetch_n && !o_cpu_phase_flag) else $error("halt status wrong");

  chk_sysclk_half: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // clock out
    i_clk_en |=> o_sys_clk_out != $past(o_sys_clk_out)) else $error("system clock out not toggling");

  chk_wait_stretch: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // not-ready
    st_reg.state == S_T2 && wait_req && i_clk_en |=> st_reg.state == S_TW && o_cycle_clk && !o_mem_cycle_n
      == pbc_is_mem(st_reg.kind)) else $error("wait state not inserted");

  chk_read_capture: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // read data
    s_read_end |=> o_cyc_done && o_rd_n && o_cyc_rdata == $past(st_reg.din2)) else $error("read data lost");

  chk_write_valid: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // write data
    !o_wr_n |-> o_data_oe && o_data == st_reg.wdata) else $error("write strobe without valid data");
endmodule : pbc_bus_ctrl

// ===== bench/pbc_mem_model.sv
// partner model: memory and I/O device on the external bus
`timescale 1ns/1ps
module pbc_mem_model import pbc_pkg::*; (
  input wire logic i_ref_clk,
  input wire logic i_slow,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_data,
  input wire logic i_data_oe,
  input wire logic i_mem_cycle_n,
  input wire logic i_io_cycle_n,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic i_strobe_oe,
  output logic [DATA_W-1:0] o_bus,
  output logic o_wait_n,
  output logic [DATA_W-1:0] o_wr_seen
);
  logic [DATA_W-1:0] junk_reg = 8'h00;
  logic [3:0] cnt_reg = 4'h0;
  logic sel;
  assign sel = i_strobe_oe & ~(i_mem_cycle_n & i_io_cycle_n);
  // released bus shows a pattern that flips every cycle
  assign o_bus = (sel & ~i_rd_n) ? (i_addr[7:0] ^ 8'hC3) : (i_data_oe ? i_data : junk_reg);
  // slow mode: not-ready stays low until three strobe cycles have passed
  assign o_wait_n = ~i_slow | (cnt_reg > 4'h2);
  always @(posedge i_ref_clk) begin
    junk_reg <= ~o_bus;
    cnt_reg <= sel ? cnt_reg + 4'h1 : 4'h0;
    if (sel & ~i_wr_n) o_wr_seen <= i_data;
  end
endmodule : pbc_mem_model

// ===== bench/pbc_bus_ctrl_tb.sv
// testbench: bus pin controller against a memory and I/O partner
`timescale 1ns/1ps
module pbc_bus_ctrl_tb import pbc_pkg::*; ();
  logic i_ref_clk = 1'b0, i_rst_b = 1'b0, i_cyc_req = 1'b0, i_cyc_dma = 1'b0, i_instr_end = 1'b0;
  logic i_int_en = 1'b0, i_halt_req = 1'b0, i_sleep_req = 1'b0, i_timer_pulse_out_sel = 1'b0, i_timer_pulse = 1'b0;
  logic i_bus_hold_request_n = 1'b1, i_nmi_n = 1'b1, i_irq0_n = 1'b1, i_irq1_n = 1'b1;
  logic i_xfer_request0_n = 1'b1, slow = 1'b0, s, wait_n;
  pbc_cyc_type i_cyc_kind = CYC_FETCH1;
  logic [ADDR_W-1:0] i_cyc_addr = 20'h00000;
  logic [DATA_W-1:0] i_cyc_wdata = 8'h00;
  logic o_cyc_ready, o_cyc_done, o_data_oe, o_mem_cycle_n, o_io_cycle_n, o_rd_n, o_wr_n, o_strobe_oe;
  logic o_refresh_cycle_n, o_first_fetch_n, o_cpu_phase_flag, o_stop_n, o_bus_grant_n, o_sys_clk_out, o_cycle_clk;
  logic [DATA_W-1:0] o_cyc_rdata, o_data, bus, wr_seen;
  logic [ADDR_W-1:0] o_addr, o_addr_oe, o_take_vec;
  logic [XREQ_N-1:0] o_xfer_ready;
  logic [XREQ_N-1:0] i_xfer_edge_mode = 2'h0, i_xfer_ack = 2'h0;
  pbc_take_type o_take;
  int fails = 0, check_count = 0, n;
  typedef struct packed {pbc_cyc_type k; logic dma; logic [19:0] a; logic [19:0] ea; logic [6:0] s;} pbc_row_type;
  // s holds mem, io, rd, wr, first-fetch, refresh, phase
  pbc_row_type rows [9] = '{
    '{CYC_FETCH1, 1'h0, 20'hABCDE, 20'hABCDE, 7'h2A}, '{CYC_FETCHN, 1'h0, 20'h12345, 20'h12345, 7'h2B},
    '{CYC_MEM_RD, 1'h1, 20'hF0F0F, 20'hF0F0F, 7'h2E}, '{CYC_MEM_WR, 1'h0, 20'h5A5A5, 20'h5A5A5, 7'h37},
    '{CYC_IO_RD, 1'h0, 20'h9ABCD, 20'h0ABCD, 7'h4F}, '{CYC_IO_WR, 1'h0, 20'h3F00F, 20'h0F00F, 7'h57},
    '{CYC_REFRESH, 1'h0, 20'h7654F, 20'h0004F, 7'h3D}, '{CYC_ACK0, 1'h0, 20'h45678, 20'h05678, 7'h5B},
    '{CYC_ACK12, 1'h0, 20'h11111, 20'h11111, 7'h7F}};

  always #12.5 i_ref_clk = ~i_ref_clk;

  pbc_bus_ctrl dut (.i_ref_clk, .i_rst_b, .i_clk_en(1'b1), .i_cyc_req, .i_cyc_kind, .i_cyc_dma, .i_cyc_addr,
    .i_cyc_wdata, .o_cyc_ready, .o_cyc_done, .o_cyc_rdata, .i_instr_end, .i_int_en, .i_halt_req, .i_sleep_req,
    .o_take, .o_take_vec, .i_xfer_edge_mode, .i_xfer_ack, .o_xfer_ready, .i_timer_pulse_out_sel, .i_timer_pulse,
    .i_wait_n(wait_n), .i_bus_hold_request_n, .i_nmi_n, .i_irq0_n, .i_irq1_n, .i_irq2_n(1'b1), .i_xfer_request0_n,
    .i_xfer_request1_n(1'b1), .i_data(bus), .o_data, .o_data_oe, .o_addr, .o_addr_oe, .o_mem_cycle_n,
    .o_io_cycle_n, .o_rd_n, .o_wr_n, .o_strobe_oe, .o_refresh_cycle_n, .o_first_fetch_n, .o_cpu_phase_flag,
    .o_stop_n, .o_bus_grant_n, .o_sys_clk_out, .o_cycle_clk);

  pbc_mem_model partner (.i_ref_clk, .i_slow(slow), .i_addr(o_addr), .i_data(o_data), .i_data_oe(o_data_oe),
    .i_mem_cycle_n(o_mem_cycle_n), .i_io_cycle_n(o_io_cycle_n), .i_rd_n(o_rd_n), .i_wr_n(o_wr_n),
    .i_strobe_oe(o_strobe_oe), .o_bus(bus), .o_wait_n(wait_n), .o_wr_seen(wr_seen));

  // ****************************************
  // helper tasks
  // ****************************************
  task automatic chk(input string nm, input logic [19:0] exp, input logic [19:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize

  task automatic step(input int k);
    repeat (k) @(posedge i_ref_clk);
    #2;
  endtask : step

  task automatic wait_for(input string nm, ref logic sig, input logic lvl);
    int k = 0;
    while (sig !== lvl && k < 20) begin
      step(1);
      k++;
    end
    chk(nm, lvl, sig);
    if (sig !== lvl) summarize();
  endtask : wait_for

  // leaves the cycle in its second bus state
  task automatic start(input pbc_cyc_type k, input logic [19:0] a, input logic dma);
    wait_for("cycle ready", o_cyc_ready, 1'b1);
    i_cyc_kind = k;
    i_cyc_addr = a;
    i_cyc_wdata = ~a[7:0];
    i_cyc_dma = dma;
    i_cyc_req = 1'b1;
    step(1);
    i_cyc_req = 1'b0;
    step(1);
  endtask : start

  task automatic end_cyc(output int k);
    k = 0;
    do begin
      step(1);
      k++;
    end while (o_cyc_done !== 1'b1 && k < 12);
    if (o_cyc_done !== 1'b1) begin
      chk("cycle done", 20'h00001, o_cyc_done);
      summarize();
    end
  endtask : end_cyc

  task automatic take(input pbc_take_type e);
    i_instr_end = 1'b1;
    step(1);
    i_instr_end = 1'b0;
    chk("take code", e, o_take);
    step(1);
  endtask : take

  // ****************************************
  // stimulus and checks
  // ****************************************
  initial begin
    step(8);
    chk("reset pins", 20'h01FF8, {o_mem_cycle_n, o_io_cycle_n, o_rd_n, o_wr_n, o_strobe_oe, o_refresh_cycle_n,
      o_first_fetch_n, o_stop_n, o_bus_grant_n, o_cpu_phase_flag, o_sys_clk_out, o_cycle_clk, o_data_oe});
    chk("reset address drive", 20'h00000, o_addr_oe);
    i_rst_b = 1'b1;
    step(1);
    s = o_sys_clk_out;
    step(1);
    chk("system clock", {~s}, o_sys_clk_out);
    foreach (rows[i]) begin
      start(rows[i].k, rows[i].a, rows[i].dma);
      chk("address", rows[i].ea, o_addr);
      chk("strobes", rows[i].s, {o_mem_cycle_n, o_io_cycle_n, o_rd_n, o_wr_n, o_first_fetch_n,
        o_refresh_cycle_n, o_cpu_phase_flag});
      chk("data drive", {~rows[i].s[3]}, o_data_oe);
      chk("cycle clock", 20'h00001, o_cycle_clk);
      end_cyc(n);
      chk("cycle length", 20'h00002, n);
      if (!rows[i].s[4]) chk("read data", rows[i].ea[7:0] ^ 8'hC3, o_cyc_rdata);
      if (!rows[i].s[3]) chk("write data", {~rows[i].a[7:0]}, wr_seen);
    end
    $display("test cycle table done");
    slow = 1'b1;
    step(3);
    start(CYC_MEM_RD, 20'h0F0F0, 1'b0);
    end_cyc(n);
    chk("wait states", 20'h00001, n > 2 && n < 12);
    chk("slow read data", 20'h00033, o_cyc_rdata);
    slow = 1'b0;
    $display("test wait states done");
    i_int_en = 1'b1;
    i_nmi_n = 1'b0;
    i_irq0_n = 1'b0;
    i_irq1_n = 1'b0;
    step(4);
    take(TAKE_NMI);
    chk("nmi vector", 20'h00066, o_take_vec);
    take(TAKE_IRQ0);
    i_irq0_n = 1'b1;
    step(3);
    take(TAKE_IRQ12);
    i_int_en = 1'b0;
    step(1);
    take(TAKE_NONE);
    i_irq1_n = 1'b1;
    i_nmi_n = 1'b1;
    $display("test interrupts done");
    start(CYC_MEM_RD, 20'h00100, 1'b0);
    i_bus_hold_request_n = 1'b0;
    chk("grant in cycle", 20'h00001, o_bus_grant_n);
    end_cyc(n);
    chk("cycle before grant", 20'h00002, n);
    wait_for("grant", o_bus_grant_n, 1'b0);
    chk("float", 20'h00000, {o_addr_oe[0], o_addr_oe[19], o_data_oe, o_strobe_oe, o_cyc_ready});
    i_int_en = 1'b1;
    i_irq0_n = 1'b0;
    step(3);
    take(TAKE_NONE);
    chk("grant held", 20'h00000, o_bus_grant_n);
    i_irq0_n = 1'b1;
    i_int_en = 1'b0;
    i_bus_hold_request_n = 1'b1;
    wait_for("grant end", o_bus_grant_n, 1'b1);
    $display("test bus hold done");
    i_halt_req = 1'b1;
    step(1);
    i_halt_req = 1'b0;
    wait_for("halt", o_stop_n, 1'b0);
    chk("halt status", 20'h00000, {o_cpu_phase_flag, o_first_fetch_n});
    i_irq1_n = 1'b0;
    wait_for("wake", o_stop_n, 1'b1);
    i_irq1_n = 1'b1;
    step(3);
    i_sleep_req = 1'b1;
    step(1);
    i_sleep_req = 1'b0;
    wait_for("sleep", o_stop_n, 1'b0);
    chk("sleep status", 20'h00001, o_first_fetch_n);
    step(3);
    chk("sleep held", 20'h00000, o_stop_n);
    i_irq1_n = 1'b0;
    wait_for("wake", o_stop_n, 1'b1);
    i_irq1_n = 1'b1;
    $display("test stop states done");
    i_xfer_request0_n = 1'b0;
    step(4);
    chk("transfer ready", 20'h00001, o_xfer_ready[0]);
    i_xfer_request0_n = 1'b1;
    step(4);
    chk("transfer idle", 20'h00000, o_xfer_ready[0]);
    i_xfer_edge_mode = 2'h1;
    i_xfer_ack = 2'h1;
    step(1);
    i_xfer_ack = 2'h0;
    chk("edge idle", 20'h00000, o_xfer_ready[0]);
    i_xfer_request0_n = 1'b0;
    step(4);
    i_xfer_request0_n = 1'b1;
    step(4);
    chk("edge held", 20'h00001, o_xfer_ready[0]);
    i_xfer_ack = 2'h1;
    step(1);
    i_xfer_ack = 2'h0;
    chk("edge cleared", 20'h00000, o_xfer_ready[0]);
    i_timer_pulse_out_sel = 1'b1;
    i_timer_pulse = 1'b1;
    step(2);
    chk("timer pin", 20'h00003, {o_addr[18], o_addr_oe[18]});
    i_rst_b = 1'b0;
    i_timer_pulse_out_sel = 1'b0;
    step(2);
    chk("reset pin role", 20'h00000, o_addr_oe);
    i_rst_b = 1'b1;
    $display("test pins and reset done");
    summarize();
  end
endmodule : pbc_bus_ctrl_tb
